// ===== hw/lsau_pkg.sv
// Package of constants and types for the load/store address unit
package lsau_pkg;
    // ========================================
    // Data units
    localparam int WORD_W = 32;
    localparam int HALF_W = 16;
    localparam int DWORD_W = 64;
    localparam int BYTE_W = 8;
    localparam int REG_W = 8;
    localparam int CONST_W = 8;
    localparam int BOOL_BIT = 31;
    localparam logic [7:0] MULTI_MAX = 8'hc0;
    localparam logic [7:0] MULTI_ONE = 8'h01;
    localparam logic [31:0] WORD_STEP = 32'h0000_0004;
    localparam logic [1:0] LANE_LAST = 2'h3;

    // ========================================
    // Access sizes
    typedef enum logic [1:0] {
        LSAU_SZ_BYTE = 2'h0,
        LSAU_SZ_HALF = 2'h1,
        LSAU_SZ_WORD = 2'h2
    } lsau_size_t;

    // ========================================
    // Address spaces
    typedef enum logic [1:0] {
        LSAU_SP_MEM = 2'h0,
        LSAU_SP_IO = 2'h1,
        LSAU_SP_COP = 2'h2,
        LSAU_SP_ROM = 2'h3
    } lsau_space_t;

    // ========================================
    // Controller states, one-hot
    typedef enum logic [3:0] {
        LSAU_IDLE = 4'h1,
        LSAU_LAUNCH = 4'h2,
        LSAU_ACCESS = 4'h4,
        LSAU_SUSP = 4'h8
    } lsau_state_t;
endpackage : lsau_pkg

// ===== hw/lsau_align_if.sv
// Interface between the controller and the alignment checker
interface lsau_align_if;
    logic [31:0] addr;
    lsau_pkg::lsau_size_t size;
    logic left_to_right;
    logic trap_en;
    logic misalign;
    logic trap;
    logic [1:0] lane;
    logic [31:0] addr_out;

    modport chk (
        input addr,
        input size,
        input left_to_right,
        input trap_en,
        output misalign,
        output trap,
        output lane,
        output addr_out
    );
    modport user (
        output addr,
        output size,
        output left_to_right,
        output trap_en,
        input misalign,
        input trap,
        input lane,
        input addr_out
    );
endinterface : lsau_align_if

// ===== hw/lsau_align_chk.sv
// Alignment checker: misalignment, trap decision, lane and truncation
module lsau_align_chk (
    lsau_align_if.chk a
);
    // ========================================
    // Alignment decode
    always_comb begin
        logic [1:0] num;
        num = a.addr[1:0];
        a.misalign = 1'b0;
        a.addr_out = a.addr;
        case (a.size)
            lsau_pkg::LSAU_SZ_WORD: begin
                a.misalign = |a.addr[1:0]; // RQ17
                a.addr_out = {a.addr[31:2], 2'h0}; // RQ18
                num = 2'h0;
            end
            lsau_pkg::LSAU_SZ_HALF: begin
                a.misalign = a.addr[0]; // RQ17
                a.addr_out = {a.addr[31:1], 1'h0}; // RQ18
                num = {a.addr[1], 1'h0}; // RQ16
            end
            default: begin
                num = a.addr[1:0]; // RQ16
            end
        endcase
        a.trap = a.trap_en & a.misalign; // RQ18
        // Numbering direction steers the physical lane
        if (a.left_to_right) begin
            a.lane = lsau_pkg::LANE_LAST - num; // RQ3
        end else begin
            a.lane = num; // RQ3
        end
    end
endmodule : lsau_align_chk

// ===== hw/lsau_core.sv
// Load/store address unit: sourcing, space select, sequencing, interlock
// Notes on behaviour
// RQ1: Word 32, half 16, double 64, byte 8.
// RQ2: Boolean lives in word MSB, 1 true.
// RQ3: Byte numbering direction set by configuration.
// RQ4: Only loads/stores transfer; one word each.
// RQ5: Multiple transfers sequential, up to 192 words.
// RQ6: Multiple transfer suspends and resumes exactly.
// RQ7: Address from register or 8-bit constant, unmodified.
// RQ8: Pending load interlocks its consumers.
// RQ9: Four separate 32-bit address spaces.
// RQ10: Data translation enable separate from fetch.
// RQ11: Supervisor may bypass translation per access.
// RQ12: Instruction fields pick memory, I/O, coprocessor.
// RQ13: Translation may redirect memory access to I/O.
// RQ14: Status bit picks fetch space memory or ROM.
// RQ15: No data access to instruction ROM.
// RQ16: Low address bits give byte/half number.
// RQ17: Misalignment detected per access size.
// RQ18: Optional trap, else low bits truncated.
// RQ19: Fetches are word-aligned 32-bit words.
// RQ20: Trapped access never reaches the bus.
module lsau_core (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic req_valid,
    input wire logic req_store,
    input wire logic req_multi,
    input wire logic [7:0] req_count,
    input wire lsau_pkg::lsau_size_t req_size,
    input wire logic req_use_const,
    input wire logic [31:0] req_reg_addr,
    input wire logic [7:0] req_const_addr,
    input wire lsau_pkg::lsau_space_t req_space,
    input wire logic req_phys,
    input wire logic [7:0] req_first_reg,
    input wire logic [31:0] store_data,
    input wire logic supervisor,
    input wire logic data_xlat_en,
    input wire logic fetch_xlat_en,
    input wire logic fetch_from_rom,
    input wire logic left_to_right,
    input wire logic align_trap_en,
    input wire logic xlat_to_io,
    input wire logic suspend,
    input wire logic resume,
    input wire logic fetch_req,
    input wire logic [31:0] fetch_pc,
    input wire logic ext_ack,
    input wire logic [31:0] ext_rdata,
    output logic req_ready,
    output logic ext_req,
    output logic ext_write,
    output lsau_pkg::lsau_space_t ext_space,
    output logic [31:0] ext_addr,
    output logic [31:0] ext_wdata,
    output logic ext_xlat,
    output logic [1:0] ext_lane,
    output logic [7:0] cur_reg,
    output logic [7:0] words_left,
    output logic suspended,
    output logic wb_valid,
    output logic [7:0] wb_reg,
    output logic [31:0] wb_data,
    output logic wb_bool,
    output logic ilk_busy,
    output logic [7:0] ilk_reg,
    output logic align_trap,
    output logic fetch_valid,
    output lsau_pkg::lsau_space_t fetch_space,
    output logic [31:0] fetch_addr,
    output logic fetch_xlat
);
    // ========================================
    // Clock and reset shared by every check below
    default clocking lsau_cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);

    // ========================================
    // State record
    typedef struct packed {
        lsau_pkg::lsau_state_t st;
        logic ready;
        logic req;
        logic write;
        lsau_pkg::lsau_space_t space;
        logic [31:0] addr;
        logic [31:0] wdata;
        logic xlat;
        logic [1:0] lane;
        logic [7:0] left;
        logic [7:0] creg;
        logic wbv;
        logic [7:0] wbr;
        logic [31:0] wbd;
        logic wbb;
        logic ilk;
        logic trap;
        logic fv;
        lsau_pkg::lsau_space_t fsp;
        logic [31:0] fa;
        logic fx;
    } lsau_core_t;

    lsau_core_t s_reg;
    lsau_core_t s_next;

    // ========================================
    // Alignment checker on the request address
    lsau_align_if al ();
    logic [31:0] src_addr;
    logic data_xlat;
    logic [7:0] cnt_clamped;

    // Address comes straight from register or zero-extended constant
    assign src_addr = req_use_const ? {24'h0, req_const_addr}
                                    : req_reg_addr; // RQ7
    assign al.addr = src_addr;
    assign al.size = req_multi ? lsau_pkg::LSAU_SZ_WORD : req_size;
    assign al.left_to_right = left_to_right;
    assign al.trap_en = align_trap_en;

    lsau_align_chk u_chk (
        .a(al)
    );

    // Data translation: memory space only, supervisor may bypass
    assign data_xlat = (req_space == lsau_pkg::LSAU_SP_MEM) & data_xlat_en
                       & ~(req_phys & supervisor); // RQ10 RQ11
    // Count clamped to the register file limit
    assign cnt_clamped = (req_count == 8'h00) ? lsau_pkg::MULTI_ONE :
        (req_count > lsau_pkg::MULTI_MAX) ? lsau_pkg::MULTI_MAX
                                          : req_count; // RQ5

    // ========================================
    // Next-state logic
    always_comb begin
        s_next = s_reg;
        s_next.wbv = 1'b0;
        s_next.trap = 1'b0;
        s_next.fv = 1'b0;
        // Fetch path: word aligned, space from status bit
        if (fetch_req) begin
            s_next.fv = 1'b1;
            s_next.fa = {fetch_pc[31:2], 2'h0}; // RQ19
            s_next.fsp = fetch_from_rom ? lsau_pkg::LSAU_SP_ROM
                                        : lsau_pkg::LSAU_SP_MEM; // RQ14
            s_next.fx = fetch_xlat_en & ~fetch_from_rom; // RQ10
        end
        case (s_reg.st)
            lsau_pkg::LSAU_IDLE: begin
                if (req_valid & al.trap) begin
                    s_next.trap = 1'b1; // RQ20
                end else if (req_valid) begin
                    s_next.st = lsau_pkg::LSAU_LAUNCH; // RQ4
                    s_next.write = req_store;
                    s_next.addr = al.addr_out; // RQ18
                    s_next.lane = al.lane; // RQ3
                    s_next.xlat = data_xlat;
                    // ROM space is never a data target
                    if (req_space == lsau_pkg::LSAU_SP_ROM) begin
                        s_next.space = lsau_pkg::LSAU_SP_MEM; // RQ15
                    end else if (data_xlat & xlat_to_io) begin
                        s_next.space = lsau_pkg::LSAU_SP_IO; // RQ13
                    end else begin
                        s_next.space = req_space; // RQ9 RQ12
                    end
                    s_next.left = req_multi ? cnt_clamped
                                            : lsau_pkg::MULTI_ONE; // RQ4
                    s_next.creg = req_first_reg;
                    s_next.ilk = ~req_store; // RQ8
                end
            end
            lsau_pkg::LSAU_LAUNCH: begin
                // Register file shows cur_reg; capture its store data
                s_next.wdata = store_data;
                s_next.req = 1'b1;
                s_next.st = lsau_pkg::LSAU_ACCESS;
            end
            lsau_pkg::LSAU_ACCESS: begin
                if (ext_ack) begin
                    s_next.req = 1'b0;
                    if (!s_reg.write) begin
                        s_next.wbv = 1'b1;
                        s_next.wbr = s_reg.creg;
                        s_next.wbd = ext_rdata; // RQ1
                        s_next.wbb = ext_rdata[lsau_pkg::BOOL_BIT]; // RQ2
                    end
                    s_next.left = s_reg.left - 8'h01;
                    if (s_reg.left == lsau_pkg::MULTI_ONE) begin
                        s_next.st = lsau_pkg::LSAU_IDLE;
                        s_next.ilk = 1'b0; // RQ8
                    end else begin
                        s_next.addr = s_reg.addr
                                      + lsau_pkg::WORD_STEP; // RQ5
                        s_next.creg = s_reg.creg + 8'h01; // RQ5
                        s_next.st = suspend ? lsau_pkg::LSAU_SUSP
                                            : lsau_pkg::LSAU_LAUNCH; // RQ6
                    end
                end
            end
            lsau_pkg::LSAU_SUSP: begin
                // Address, register and count are held for the restart
                if (resume) begin
                    s_next.st = lsau_pkg::LSAU_LAUNCH; // RQ6
                end
            end
            default: begin
                s_next.st = lsau_pkg::LSAU_IDLE;
            end
        endcase
        s_next.ready = (s_next.st == lsau_pkg::LSAU_IDLE);
    end

    // ========================================
    // State register
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            s_reg <= '{st: lsau_pkg::LSAU_IDLE, ready: 1'b1,
                       space: lsau_pkg::LSAU_SP_MEM,
                       fsp: lsau_pkg::LSAU_SP_MEM, default: '0};
        end else begin
            s_reg <= s_next;
        end
    end

    // ========================================
    // Outputs straight from the state record
    assign req_ready = s_reg.ready;
    assign ext_req = s_reg.req;
    assign ext_write = s_reg.write;
    assign ext_space = s_reg.space;
    assign ext_addr = s_reg.addr;
    assign ext_wdata = s_reg.wdata;
    assign ext_xlat = s_reg.xlat;
    assign ext_lane = s_reg.lane;
    assign cur_reg = s_reg.creg;
    assign words_left = s_reg.left;
    assign suspended = (s_reg.st == lsau_pkg::LSAU_SUSP);
    assign wb_valid = s_reg.wbv;
    assign wb_reg = s_reg.wbr;
    assign wb_data = s_reg.wbd;
    assign wb_bool = s_reg.wbb;
    assign ilk_busy = s_reg.ilk;
    assign ilk_reg = s_reg.creg;
    assign align_trap = s_reg.trap;
    assign fetch_valid = s_reg.fv;
    assign fetch_space = s_reg.fsp;
    assign fetch_addr = s_reg.fa;
    assign fetch_xlat = s_reg.fx;

    // ========================================
    // Checks
    AST_NO_ROM_DATA: assert property ( // RQ15
        ext_req |-> ext_space != lsau_pkg::LSAU_SP_ROM)
        else $error("data access aimed at instruction ROM");
    AST_TRAP_NO_BUS: assert property ( // RQ20
        align_trap |-> !ext_req ##1 !ext_req)
        else $error("trapped access reached the bus");
    AST_WORD_ALIGN: assert property ( // RQ18
        (req_valid && req_ready && !al.trap
            && al.size != lsau_pkg::LSAU_SZ_BYTE)
        |=> ext_addr[0] == 1'b0 && (ext_addr[1] == 1'b0
            || $past(al.size == lsau_pkg::LSAU_SZ_HALF)))
        else $error("non-byte access left unaligned");
    AST_MULTI_STEP: assert property ( // RQ5
        (ext_req && ext_ack && words_left > 8'h01 && !suspend)
        |-> ##2 ext_req && ext_addr == $past(ext_addr, 2) + 32'h4
            && cur_reg == $past(cur_reg, 2) + 8'h01)
        else $error("multiple transfer did not step by one word");
    AST_MAX_COUNT: assert property ( // RQ5
        words_left <= 8'hc0)
        else $error("word count beyond 192");
    AST_SUSP_HOLD: assert property ( // RQ6
        (suspended && !resume) |=> suspended && $stable(ext_addr)
            && $stable(cur_reg) && $stable(words_left))
        else $error("suspended transfer lost its place");
    AST_RESUME: assert property ( // RQ6
        (suspended && resume) |=> !suspended ##1 ext_req)
        else $error("resumed transfer did not restart");
    AST_LOAD_WB: assert property ( // RQ2
        (ext_req && ext_ack && !ext_write) |=> wb_valid
            && wb_data == $past(ext_rdata) && wb_reg == $past(cur_reg)
            && wb_bool == $past(ext_rdata[31]))
        else $error("load result not written back");
    AST_ILK: assert property ( // RQ8
        (ext_req && !ext_write) |-> ilk_busy)
        else $error("pending load not interlocked");
    AST_FETCH: assert property ( // RQ14 RQ19
        fetch_req |=> fetch_valid && fetch_addr[1:0] == 2'h0
            && (fetch_space == lsau_pkg::LSAU_SP_ROM) == $past(fetch_from_rom))
        else $error("fetch space or alignment wrong");
    AST_BYPASS: assert property ( // RQ11
        (req_valid && req_ready && req_phys && supervisor && !al.trap)
        |=> !ext_xlat)
        else $error("supervisor real access was translated");
    AST_ONE_WORD: assert property ( // RQ4
        (req_valid && req_ready && !req_multi && !al.trap)
        |=> words_left == lsau_pkg::MULTI_ONE && !req_ready)
        else $error("single access not sized to one word");
    AST_MISALIGN_TRAP: assert property ( // RQ17
        (req_valid && req_ready && align_trap_en && !req_multi
            && ((req_size == lsau_pkg::LSAU_SZ_WORD
                    && src_addr[1:0] != 2'h0)
                || (req_size == lsau_pkg::LSAU_SZ_HALF && src_addr[0])))
        |=> align_trap && req_ready)
        else $error("misaligned access did not trap");
endmodule : lsau_core

// ===== bench/lsau_mem_model.sv
// Behavioural external memory that answers the load/store unit
module lsau_mem_model (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic ext_req,
    input wire logic [31:0] ext_addr,
    input wire logic [3:0] dly,
    output logic ext_ack,
    output logic [31:0] ext_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt;

    // ========================================
    // Answer after dly waiting cycles; data is only valid with ack
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ext_ack <= 1'b0;
            cnt <= 4'h0;
            ext_rdata <= 32'h0;
        end else if (ext_ack) begin
            ext_ack <= 1'b0;
            ext_rdata <= ~ext_rdata; // Stale data never stands still
        end else if (ext_req && cnt >= dly) begin
            ext_ack <= 1'b1;
            cnt <= 4'h0;
            ext_rdata <= ~ext_addr;
        end else begin
            cnt <= ext_req ? cnt + 4'h1 : 4'h0;
            ext_rdata <= ~ext_rdata;
        end
    end
endmodule : lsau_mem_model

// ===== bench/load_store_address_unit_tb_top.sv
// Self-checking bench for the load/store address unit
`define CHK(n, e, g) begin \
    checks_done++; \
    if ((g) !== (e)) begin \
        bad_count++; \
        $display("[ERR] %s exp %h got %h", n, (e), (g)); \
    end \
end

module load_store_address_unit_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    // ========================================
    // Stimulus and observed signals
    logic mclk, nrst, req_valid, req_store, req_multi, req_use_const;
    logic req_phys, supervisor, data_xlat_en, fetch_xlat_en, fetch_from_rom;
    logic left_to_right, align_trap_en, xlat_to_io, suspend, resume;
    logic fetch_req, ext_ack, req_ready, ext_req, ext_write, ext_xlat;
    logic suspended, wb_valid, wb_bool, ilk_busy, align_trap, fetch_valid;
    logic fetch_xlat;
    logic [7:0] req_count, req_const_addr, req_first_reg, cur_reg;
    logic [7:0] words_left, wb_reg, ilk_reg;
    logic [31:0] req_reg_addr, store_data, fetch_pc, ext_rdata, ext_addr;
    logic [31:0] ext_wdata, wb_data, fetch_addr;
    logic [1:0] ext_lane;
    logic [3:0] dly;
    lsau_pkg::lsau_size_t req_size;
    lsau_pkg::lsau_space_t req_space, ext_space, fetch_space;
    int bad_count = 0;
    int checks_done = 0;

    typedef struct {
        logic st, uc, ph, su, xe, xio, ltr, te, tp;
        logic [1:0] sz, sp, es, ln, ex;
        logic [31:0] ra, ea;
        logic [7:0] ca;
    } lsau_row_t;

    // st uc ph su xe xio ltr te tp sz sp es ln ex(2=any) ra ea ca
    lsau_row_t rows[13] = '{
        '{0,0,0,0,1,0,0,0,0,2,0,0,0,1,32'h2000,32'h2000,0},
        '{1,1,0,0,1,0,0,0,0,2,1,1,0,0,32'hffff_ff00,32'h84,8'h84},
        '{0,0,0,0,0,0,0,0,0,2,2,2,0,0,32'h8000_3000,32'h8000_3000,0},
        '{0,0,0,0,0,0,0,0,0,2,3,0,0,0,32'h2010,32'h2010,0},
        '{0,0,0,0,0,0,0,0,0,0,0,0,1,0,32'h2001,32'h2000,0},
        '{0,0,0,0,0,0,1,0,0,0,0,0,2,0,32'h2001,32'h2000,0},
        '{0,0,0,0,0,0,0,0,0,2,0,0,0,0,32'h2006,32'h2004,0},
        '{0,0,0,0,0,0,0,1,1,2,0,0,0,0,32'h2006,0,0},
        '{0,0,0,0,0,0,0,1,1,1,0,0,0,0,32'h2001,0,0},
        '{0,0,0,0,0,0,0,1,0,1,0,0,0,0,32'h2002,32'h2002,0},
        '{0,0,1,1,1,0,0,0,0,2,0,0,0,0,32'h3000,32'h3000,0},
        '{0,0,1,0,1,0,0,0,0,2,0,0,0,1,32'h3000,32'h3000,0},
        '{0,0,0,0,1,1,0,0,0,2,0,1,0,2,32'h3004,32'h3004,0}
    };

    lsau_core u_dut (.mclk, .nrst, .req_valid, .req_store, .req_multi,
        .req_count, .req_size, .req_use_const, .req_reg_addr, .req_const_addr,
        .req_space, .req_phys, .req_first_reg, .store_data, .supervisor,
        .data_xlat_en, .fetch_xlat_en, .fetch_from_rom, .left_to_right,
        .align_trap_en, .xlat_to_io, .suspend, .resume, .fetch_req, .fetch_pc,
        .ext_ack, .ext_rdata, .req_ready, .ext_req, .ext_write, .ext_space,
        .ext_addr, .ext_wdata, .ext_xlat, .ext_lane, .cur_reg, .words_left,
        .suspended, .wb_valid, .wb_reg, .wb_data, .wb_bool, .ilk_busy,
        .ilk_reg, .align_trap, .fetch_valid, .fetch_space, .fetch_addr,
        .fetch_xlat);

    lsau_mem_model u_mem (.mclk, .nrst, .ext_req, .ext_addr, .dly, .ext_ack,
        .ext_rdata);

    // ========================================
    // Clock and register-file stand-in for store data
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    always @(negedge mclk) store_data <= {24'ha5a5a5, cur_reg};

    // ========================================
    // Verdict
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : summarize

    // One request, collecting every bus word and write-back until idle
    task automatic run(input lsau_row_t r, input logic mu,
                       input logic [7:0] cnt, input logic [7:0] fr,
                       input int nw, input string nm);
        logic [31:0] q_a[$];
        logic [31:0] q_w[$];
        logic [7:0] q_r[$];
        logic prev, trp, sus, done, su0, x0, w0;
        logic [1:0] sp0, ln0;
        logic [31:0] wm;
        logic [7:0] rn;
        wm = (r.sz == 2'h0) ? 32'hffff_fffc : 32'hffff_ffff;
        {prev, trp, sus, done} = '0;
        su0 = suspend;
        req_store = r.st;
        req_multi = mu;
        req_count = cnt;
        req_size = lsau_pkg::lsau_size_t'(r.sz);
        req_use_const = r.uc;
        req_reg_addr = r.ra;
        req_const_addr = r.ca;
        req_space = lsau_pkg::lsau_space_t'(r.sp);
        req_phys = r.ph;
        req_first_reg = fr;
        supervisor = r.su;
        data_xlat_en = r.xe;
        xlat_to_io = r.xio;
        left_to_right = r.ltr;
        align_trap_en = r.te;
        req_valid = 1'b1;
        for (int i = 0; i < 1500 && !done; i++) begin
            @(negedge mclk);
            // Strobes drop once, so no signal is set twice in a step
            if (i == 0) req_valid = 1'b0;
            if (resume) resume = 1'b0;
            if (align_trap === 1'b1) trp = 1'b1;
            if (ext_req === 1'b1 && !prev) begin
                if (q_a.size() == 0) begin
                    {sp0, x0, ln0, w0} = {ext_space, ext_xlat, ext_lane,
                                          ext_write};
                end
                q_a.push_back(ext_addr);
                q_w.push_back(ext_wdata);
                rn = fr + 8'(q_a.size() - 1);
                `CHK("left", 8'(nw - q_a.size() + 1), words_left)
                `CHK("cur_reg", rn, cur_reg)
                if (!r.st) `CHK("ilk", {1'b1, rn}, {ilk_busy, ilk_reg})
            end
            prev = ext_req;
            if (wb_valid === 1'b1) begin
                q_r.push_back(wb_reg);
                `CHK("wb_data", ~q_a[$], wb_data)
                `CHK("wb_bool", ~q_a[$][31], wb_bool)
            end
            if (suspended === 1'b1 && suspend) begin
                sus = 1'b1;
                suspend = 1'b0;
                resume = 1'b1;
            end
            if (i >= 3 && req_ready === 1'b1) done = 1'b1;
        end
        if (!done) begin
            bad_count++;
            summarize();
        end
        `CHK("trap", r.tp, trp)
        `CHK("words", nw, q_a.size())
        `CHK("suspend", su0, sus)
        foreach (q_a[n]) begin
            `CHK("addr", r.ea + 32'(4 * n), q_a[n] & wm)
            if (r.st) `CHK("wdata", {24'ha5a5a5, fr + 8'(n)}, q_w[n])
            else `CHK("wb_reg", fr + 8'(n), q_r[n])
        end
        if (q_a.size() > 0) begin
            `CHK("write", r.st, w0)
            `CHK("space", r.es, sp0)
            if (r.ex != 2'h2) `CHK("xlat", r.ex[0], x0)
            if (r.sz == 2'h0) `CHK("lane", r.ln, ln0)
        end
        $display("test %s done", nm);
    endtask : run

    // ========================================
    // Main sequence
    initial begin
        lsau_row_t m;
        {nrst, req_valid, req_store, req_multi, req_use_const, req_phys} = '0;
        {supervisor, data_xlat_en, fetch_xlat_en, fetch_from_rom} = '0;
        {left_to_right, align_trap_en, xlat_to_io, suspend, resume} = '0;
        {fetch_req, req_count, req_const_addr, req_first_reg, dly} = '0;
        {req_reg_addr, fetch_pc} = '0;
        req_size = lsau_pkg::LSAU_SZ_WORD;
        req_space = lsau_pkg::LSAU_SP_MEM;
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        `CHK("rst_ready", 1'b1, req_ready)
        `CHK("rst_req", 1'b0, ext_req)
        $display("test reset done");
        nrst = 1'b1;
        foreach (rows[i]) begin
            run(rows[i], 1'b0, 8'h0, 8'h10, !rows[i].tp,
                $sformatf("row%0d", i));
        end
        // Slow partner, interlocked multiple load
        dly = 4'h2;
        m = rows[0];
        m.ra = 32'h400;
        m.ea = 32'h400;
        run(m, 1'b1, 8'h3, 8'h20, 3, "mload");
        // Over-long multiple store is clamped
        dly = 4'h0;
        m.st = 1'b1;
        run(m, 1'b1, 8'hc8, 8'h08, 192, "mstore_clamp");
        // Zero count moves one word
        m.st = 1'b0;
        run(m, 1'b1, 8'h0, 8'h30, 1, "mzero");
        // Suspended after the first word, then resumed
        suspend = 1'b1;
        run(m, 1'b1, 8'h3, 8'h40, 3, "msuspend");
        // Fetch space and translation, independent of data translation
        for (int k = 0; k < 2; k++) begin
            fetch_from_rom = k[0];
            fetch_xlat_en = ~k[0];
            data_xlat_en = k[0];
            fetch_pc = 32'h1003;
            fetch_req = 1'b1;
            @(negedge mclk);
            fetch_req = 1'b0;
            for (int j = 0; j < 3 && fetch_valid !== 1'b1; j++) begin
                @(negedge mclk);
            end
            `CHK("fvalid", 1'b1, fetch_valid)
            if (fetch_valid !== 1'b1) summarize();
            `CHK("faddr", 32'h1000, fetch_addr)
            `CHK("fspace", k[0] ? 2'h3 : 2'h0, fetch_space)
            `CHK("fxlat", ~k[0], fetch_xlat)
            `CHK("noext", 1'b0, ext_req)
            @(negedge mclk);
            $display("test fetch%0d done", k);
        end
        summarize();
    end
endmodule : load_store_address_unit_tb_top
